/* File: core/maf_top.sv */
// receive-side address recognition for multiprocessor serial communication
`timescale 1ns/1ps

// Behaviour
// - Address filtering works in modes 1, 2 and 3 using the ninth bit and hardware compare.
// - In 9-bit modes a high ninth bit marks an address frame and a low one a data frame.
// - With the filter on in a 9-bit mode only a matching address frame raises the flag.
// - With the filter off every following data frame raises the flag.
// - In mode 1 with the filter on the flag rises only for stop bit 1 and a matching byte.
// - The given address compares only bit positions whose mask bit is 1.
// - The broadcast address is station address OR mask, its zero bits being ignored.
// - Station address and mask reset to 00h so that every address matches.
module maf_top
    import maf_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // special function register port
    input  wire logic [7:0]    sfr_addr,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    input  wire logic [7:0]    sfr_wdata,
    output logic      [7:0]    sfr_rdata,
    // serial port control
    input  wire logic [1:0]    uart_mode,
    input  wire logic          addr_filter_enable,
    input  wire logic          receive_flag_clear,
    output logic               receive_flag,
    // frames from the receive shifter
    input  wire logic          frame_valid,
    output logic               frame_ready,
    input  wire maf_frame_type frame_in,
    // accepted frames towards the receive buffer reader
    output logic               rx_valid,
    input  wire logic          rx_ready,
    output maf_frame_type      rx_data
);

    // ------------------------------------------------------------------
    // address compare function
    // ------------------------------------------------------------------
    // a zero mask bit makes that position a don't-care
    function automatic logic masked_match(input logic [7:0] rx_byte,
                                          input logic [7:0] addr,
                                          input logic [7:0] mask);
        masked_match = ((rx_byte ^ addr) & mask) == 8'h00;
    endfunction

    // ------------------------------------------------------------------
    // station registers
    // ------------------------------------------------------------------
    logic [7:0] station_address;
    logic [7:0] station_address_mask;

    wire logic sel_addr = sfr_addr == MAF_SFR_STATION_ADDRESS;
    wire logic sel_mask = sfr_addr == MAF_SFR_STATION_ADDRESS_MASK;

    // reset to zero leaves both addresses all don't-care
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            station_address      <= MAF_STATION_ADDRESS_RESET;
            station_address_mask <= MAF_STATION_MASK_RESET;
        end else begin
            if (sfr_wr && sel_addr) begin
                station_address <= sfr_wdata;
            end
            if (sfr_wr && sel_mask) begin
                station_address_mask <= sfr_wdata;
            end
        end
    end

    // read data is registered; unmapped locations read as zero
    wire logic [7:0] next_sfr_rdata = sel_addr ? station_address :
                                      sel_mask ? station_address_mask :
                                      MAF_SFR_UNMAPPED_READ;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= MAF_SFR_UNMAPPED_READ;
        end else if (sfr_rd) begin
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // ------------------------------------------------------------------
    // frame acceptance
    // ------------------------------------------------------------------
    wire logic [7:0] broadcast_address = station_address | station_address_mask;
    wire logic given_hit = masked_match(frame_in.data, station_address,
                                        station_address_mask);
    wire logic broadcast_hit = masked_match(frame_in.data, broadcast_address,
                                            broadcast_address);
    wire logic address_hit = given_hit || broadcast_hit;
    wire logic filtering = addr_filter_enable && (uart_mode != MAF_MODE_SHIFT);
    // ninth bit is the address mark in modes 2/3 and the stop bit in mode 1
    wire logic frame_ok = !filtering || (frame_in.ninth && address_hit);
    wire logic take = frame_valid && frame_ready;
    wire logic accept = take && frame_ok;

    // a stalled reader back-pressures the shifter instead of losing a word
    maf_buffer u_buffer (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (frame_valid && frame_ok),
        .in_ready  (frame_ready),
        .in_data   (frame_in),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // set wins over a clear in the same cycle so no frame is missed
    wire logic next_receive_flag = accept || (receive_flag && !receive_flag_clear);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_flag <= 1'b0;
        end else begin
            receive_flag <= next_receive_flag;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wire logic idle_flag = !receive_flag && !receive_flag_clear;

    a_mode0_unfiltered: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && uart_mode == MAF_MODE_SHIFT) |=> receive_flag)
        else $error("mode 0 frame did not raise the flag");

    a_data_frame_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && addr_filter_enable && uart_mode[1] && !frame_in.ninth && idle_flag)
        |=> !receive_flag)
        else $error("data frame raised the flag while filtering");

    a_mismatch_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && filtering && !address_hit && idle_flag) |=> !receive_flag)
        else $error("unmatched address raised the flag");

    a_filter_off_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && !addr_filter_enable) |=> receive_flag)
        else $error("frame with filter off did not raise the flag");

    a_mode1_stop_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && addr_filter_enable && uart_mode == MAF_MODE_8BIT && !frame_in.ninth
         && idle_flag) |=> !receive_flag)
        else $error("mode 1 frame with bad stop bit raised the flag");

    a_given_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && filtering && frame_in.ninth
         && ((frame_in.data ^ station_address) & station_address_mask) == 8'h00)
        |=> receive_flag)
        else $error("given address match did not raise the flag");

    a_broadcast_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && filtering && frame_in.ninth
         && frame_in.data == (station_address | station_address_mask)) |=> receive_flag)
        else $error("broadcast address did not raise the flag");

    a_reset_all_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && filtering && frame_in.ninth && station_address == 8'h00
         && station_address_mask == 8'h00) |=> receive_flag)
        else $error("default addresses did not match every byte");

    a_accept_buffered: assert property (@(posedge sys_clk) disable iff (!rst_n)
        accept |=> rx_valid && receive_flag)
        else $error("accepted frame not buffered next cycle");

    a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (accept && receive_flag_clear) |=> receive_flag)
        else $error("clear beat a simultaneous set");

    // ------------------------------------------------------------------
    // flag, buffer and register port checks
    // ------------------------------------------------------------------
    // a refused frame must leave a set flag alone, or software loses a pending byte
    a_flag_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (receive_flag && !receive_flag_clear)
        |=> receive_flag)
        else $error("flag fell without a clear");

    a_clear_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (receive_flag_clear && !accept)
        |=> !receive_flag)
        else $error("flag survived a clear");

    a_data_frame_dropped: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && filtering && uart_mode[1] && !frame_in.ninth && !rx_valid)
        |=> !rx_valid)
        else $error("data frame reached the reader while filtering");

    a_mode1_match_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && addr_filter_enable && uart_mode == MAF_MODE_8BIT
         && frame_in.ninth && (given_hit || broadcast_hit))
        |=> receive_flag)
        else $error("mode 1 matching frame did not raise the flag");

    a_word_carried: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (accept && !rx_valid)
        |=> rx_data == $past(frame_in))
        else $error("buffered word differs from the taken frame");

    // a stalled reader must see the same word until it takes it
    a_stall_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rx_valid && !rx_ready)
        |=> rx_valid && $stable(rx_data))
        else $error("word changed while the reader stalled");

    a_full_stalls: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (accept && rx_valid && !rx_ready)
        |=> !frame_ready)
        else $error("ready stayed high with both stages full");

    a_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sfr_wr && sel_mask)
        |=> station_address_mask == $past(sfr_wdata))
        else $error("mask write did not land");

    a_read_returns: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sfr_rd && sel_addr)
        |=> sfr_rdata == $past(station_address))
        else $error("read did not return the station address");

    a_rdata_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read strobe");

endmodule

/* File: common/maf_pkg.sv */
// shared constants and types for the multiprocessor address filter
package maf_pkg;

    // ------------------------------------------------------------------
    // special function register map
    // ------------------------------------------------------------------
    localparam logic [7:0] MAF_SFR_STATION_ADDRESS      = 8'ha9;
    localparam logic [7:0] MAF_SFR_STATION_ADDRESS_MASK = 8'hb9;
    localparam logic [7:0] MAF_STATION_ADDRESS_RESET    = 8'h00;
    localparam logic [7:0] MAF_STATION_MASK_RESET       = 8'h00;
    localparam logic [7:0] MAF_SFR_UNMAPPED_READ        = 8'h00;

    // ------------------------------------------------------------------
    // serial port mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MAF_MODE_SHIFT = 2'h0;
    localparam logic [1:0] MAF_MODE_8BIT  = 2'h1;
    localparam logic [1:0] MAF_MODE_9BIT  = 2'h2;
    localparam logic [1:0] MAF_MODE_9VAR  = 2'h3;

    // one received frame: ninth bit (or stop bit in mode 1) and data byte
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } maf_frame_type;

    localparam maf_frame_type MAF_FRAME_RESET = '{ninth: 1'b0, data: 8'h00};

endpackage

/* File: core/maf_buffer.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps

module maf_buffer
    import maf_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire maf_frame_type in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output maf_frame_type      out_data
);

    // ------------------------------------------------------------------
    // storage: output stage plus one spare stage
    // ------------------------------------------------------------------
    logic          spare_valid;
    maf_frame_type spare_data;
    logic          next_out_valid;
    maf_frame_type next_out_data;
    logic          next_spare_valid;
    maf_frame_type next_spare_data;

    wire logic push = in_valid && in_ready;
    wire logic pop  = out_valid && out_ready;

    // the spare stage only fills when the output stage is held by a stall
    always_comb begin
        next_out_valid   = out_valid;
        next_out_data    = out_data;
        next_spare_valid = spare_valid;
        next_spare_data  = spare_data;
        if (!out_valid || pop) begin
            if (spare_valid) begin
                next_out_valid   = 1'b1;
                next_out_data    = spare_data;
                next_spare_valid = push;
                next_spare_data  = in_data;
            end else begin
                next_out_valid = push;
                next_out_data  = in_data;
            end
        end else if (push) begin
            next_spare_valid = 1'b1;
            next_spare_data  = in_data;
        end
    end

    // ready is registered so the source sees a clean flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid   <= 1'b0;
            out_data    <= MAF_FRAME_RESET;
            spare_valid <= 1'b0;
            spare_data  <= MAF_FRAME_RESET;
            in_ready    <= 1'b0;
        end else begin
            out_valid   <= next_out_valid;
            out_data    <= next_out_data;
            spare_valid <= next_spare_valid;
            spare_data  <= next_spare_data;
            in_ready    <= !next_spare_valid;
        end
    end

endmodule

/* File: verification/maf_master_model.sv */
// master serial port model offering frames to the filter
`timescale 1ns/1ps
module maf_master_model
    import maf_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     frame_ready,
    output logic          frame_valid,
    output maf_frame_type frame_in
);
    initial begin
        frame_valid = 1'b0;
        frame_in    = MAF_FRAME_RESET;
    end
    // hold a frame until taken; released lines show the inverse so stale data never matches
    task automatic send(input logic ninth, input logic [7:0] data, input int gap);
        repeat (gap) @(negedge sys_clk); // slow talker
        @(negedge sys_clk);
        frame_valid = 1'b1;
        frame_in    = '{ninth: ninth, data: data};
        @(posedge sys_clk);
        while (frame_ready !== 1'b1) @(posedge sys_clk);
        @(negedge sys_clk);
        frame_valid = 1'b0;
        frame_in    = ~frame_in;
    endtask
endmodule

/* File: verification/testbench.sv */
// self-checking testbench for the multiprocessor address filter
`timescale 1ns/1ps
module testbench;
    import maf_pkg::*;
    logic          sys_clk, rst_n, sfr_wr, sfr_rd, receive_flag_clear, receive_flag;
    logic          addr_filter_enable, frame_valid, frame_ready, rx_valid, rx_ready;
    logic [7:0]    sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0]    uart_mode;
    maf_frame_type frame_in, rx_data;
    maf_frame_type got[$];
    int            err_count, n_tests;
    // {pass, ninth, byte}: first six for a4/fa, last three for a7/f9
    logic [9:0]    tbl[9] = '{10'h3a0, 10'h3a1, 10'h1a3, 10'h3fe, 10'h3ff, 10'h0a4,
                              10'h1fe, 10'h3a3, 10'h3ff};
    maf_top dut (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
                 .uart_mode, .addr_filter_enable, .receive_flag_clear, .receive_flag,
                 .frame_valid, .frame_ready, .frame_in, .rx_valid, .rx_ready, .rx_data);
    maf_master_model mst (.sys_clk, .frame_ready, .frame_valid, .frame_in);
    // free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // words handed to the reader, taken at the edge where both sides agree
    always @(posedge sys_clk) begin
        if (rx_valid && rx_ready)
            got.push_back(rx_data);
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask
    task automatic wrap_up();
        $display("%0d comparisons, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge sys_clk);
        sfr_wr    = 1'b0;
    endtask
    // read data is settled one cycle after the strobe edge
    task automatic reg_rd(input logic [7:0] a);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge sys_clk);
        sfr_rd   = 1'b0;
    endtask
    // clear the flag first so a stale set cannot pass for a new one
    task automatic frame_try(input logic [9:0] e);
        @(negedge sys_clk);
        receive_flag_clear = 1'b1;
        @(negedge sys_clk);
        receive_flag_clear = 1'b0;
        mst.send(e[8], e[7:0], 0);
        check(9'(receive_flag), 9'(e[9]), "receive flag");
        check(9'(rx_valid), 9'(e[9]), "word out");
        if (e[9])
            check(rx_data, e[8:0], "word data");
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        reg_rd(MAF_SFR_STATION_ADDRESS);
        check(9'(sfr_rdata), 9'h000, "address reset");
        reg_rd(MAF_SFR_STATION_ADDRESS_MASK);
        check(9'(sfr_rdata), 9'h000, "mask reset");
        reg_wr(8'hb8, 8'h5a);
        reg_rd(8'hb8);
        check(9'(sfr_rdata), 9'h000, "unmapped read");
        uart_mode          = MAF_MODE_9VAR;
        addr_filter_enable = 1'b1;
        frame_try(10'h35c);
        $display("done reset");
    endtask
    task automatic t_given();
        reg_wr(MAF_SFR_STATION_ADDRESS, 8'ha4);
        reg_wr(MAF_SFR_STATION_ADDRESS_MASK, 8'hfa);
        reg_rd(MAF_SFR_STATION_ADDRESS_MASK);
        check(9'(sfr_rdata), 9'h0fa, "mask readback");
        for (int m = 1; m < 4; m++) begin
            uart_mode = 2'(m);
            for (int i = 0; i < 6; i++)
                frame_try(tbl[i]);
        end
        reg_wr(MAF_SFR_STATION_ADDRESS, 8'ha7);
        reg_wr(MAF_SFR_STATION_ADDRESS_MASK, 8'hf9);
        for (int i = 6; i < 9; i++)
            frame_try(tbl[i]);
        uart_mode = MAF_MODE_SHIFT;
        frame_try(10'h2a3);
        $display("done given and broadcast");
    endtask
    task automatic t_block();
        uart_mode = MAF_MODE_9BIT;
        reg_wr(MAF_SFR_STATION_ADDRESS, 8'ha4);
        reg_wr(MAF_SFR_STATION_ADDRESS_MASK, 8'hfa);
        frame_try(10'h3a4);
        frame_try(10'h033);
        addr_filter_enable = 1'b0;
        frame_try(10'h233);
        frame_try(10'h234);
        $display("done data block");
    endtask
    // reader stalls while three words arrive; none may be lost
    task automatic t_buffer();
        @(negedge sys_clk);
        got.delete();
        rx_ready = 1'b0;
        mst.send(1'b0, 8'h11, 0);
        mst.send(1'b0, 8'h22, 2);
        fork
            mst.send(1'b0, 8'h33, 0);
        join_none
        repeat (4) @(negedge sys_clk);
        check(9'(frame_ready), 9'h000, "full buffer ready");
        check(rx_data, 9'h011, "oldest word");
        rx_ready = 1'b1;
        repeat (6) @(negedge sys_clk);
        check(9'(got.size()), 9'h003, "word count");
        for (int i = 0; i < 3; i++)
            check(got[i], 9'(8'h11 * (i + 1)), "word order");
        check(9'(frame_ready), 9'h001, "empty buffer ready");
        $display("done buffer");
    endtask
    // reset for three cycles, then run every scenario
    initial begin
        rst_n = 1'b0;
        {sfr_wr, sfr_rd, receive_flag_clear, addr_filter_enable} = 4'h0;
        {sfr_addr, sfr_wdata} = 16'h0000;
        uart_mode = MAF_MODE_SHIFT;
        rx_ready  = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_given();
        t_block();
        t_buffer();
        wrap_up();
    end
    // watchdog far beyond the roughly 150 cycles the scenarios need
    initial begin
        #50us;
        err_count++;
        $display("wrong value at %0t ns: timeout", $time);
        wrap_up();
    end
endmodule
